// File: hdl/utx_tx_port.sv
// Purpose: transmit cell-bus slave port with fifo, flow control and registers
// Assumes: cell bus clock far slower than clk; it is sampled, not used as a clock
// Notes: downstream drain is a valid/ready word stream
`timescale 1ns/10ps
module utx_tx_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic cell_bus_clock,
  input wire logic cell_write_enable_n,
  input wire logic cell_start_marker,
  input wire logic cell_word_parity,
  input wire logic [15:0] cell_data_bus,
  input wire logic [4:0] phy_port_address,
  output logic cell_space_available,
  output logic cell_space_available_oe,
  output logic cell_forwarded_pulse,
  output logic cell_forwarded_oe,
  input wire logic fwd_ready,
  output logic fwd_valid,
  output logic fwd_start,
  output logic [15:0] fwd_data
);

  // ==========================================================
  // pin synchronisation and edge finding
  utx_pkg::utx_link_t link_pins;
  utx_pkg::utx_link_t link_sync;
  utx_pkg::utx_link_t link_d_r;
  logic clk_sync;
  logic clk_d_r;
  logic link_edge;

  assign link_pins = '{en_n: cell_write_enable_n, soc: cell_start_marker,
                       par: cell_word_parity, data: cell_data_bus, addr: phy_port_address};

  utx_sync #(.WIDTH(25)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .din({cell_bus_clock, link_pins}),
    .dout({clk_sync, link_sync})
  );

  // data is taken from the sample before the rise: it was stable through the low phase
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      clk_d_r <= 1'b0;
      link_d_r <= '0;
    end
    else
    begin
      clk_d_r <= clk_sync;
      link_d_r <= link_sync;
    end
  end

  assign link_edge = clk_sync & ~clk_d_r;

  // ==========================================================
  // register state
  logic [3:0] ctrl_r;
  logic [3:0] ctrl_nxt;
  logic [2:0] status_r;
  logic [2:0] status_nxt;
  logic [2:0] mask_r;
  logic [2:0] mask_nxt;
  logic [7:0] port_r;
  logic [7:0] port_nxt;
  logic ap_wr_r;
  logic ap_wr_nxt;
  logic [7:0] ap_addr_r;
  logic [7:0] ap_addr_nxt;
  logic [31:0] hrdata_nxt;
  logic bus_take;
  logic rd_status;
  logic [2:0] ev_set;
  logic port_idle;

  logic atm_mode;
  logic wide_mode;
  logic cell_hs;
  logic mphy_mode;
  assign atm_mode = ctrl_r[utx_pkg::CTRL_ATM_BIT];
  assign wide_mode = ctrl_r[utx_pkg::CTRL_WIDE_BIT];
  assign cell_hs = ctrl_r[utx_pkg::CTRL_CELL_HS_BIT];
  assign mphy_mode = ctrl_r[utx_pkg::CTRL_MPHY_BIT];

  // ==========================================================
  // fifo state
  utx_pkg::utx_word_t mem [0:utx_pkg::FIFO_DEPTH-1];
  logic [7:0] wr_ptr_r;
  logic [7:0] wr_ptr_nxt;
  logic [7:0] rd_ptr_r;
  logic [7:0] rd_ptr_nxt;
  logic [7:0] fill;
  logic [7:0] room;
  logic [6:0] cell_pos_r;
  logic [6:0] cell_pos_nxt;
  logic [6:0] cell_words;
  logic [6:0] pos_use;
  logic sel_r;
  logic sel_nxt;
  logic drv_r;
  logic drv_nxt;
  logic clav_r;
  logic clav_nxt;
  logic clav_oe_r;
  logic clav_oe_nxt;
  logic addr_match;
  logic write_ok;
  logic wr_push;
  logic [15:0] wr_data;
  logic par_bad;
  utx_pkg::utx_word_t wr_word;
  utx_pkg::utx_word_t out_word_r;
  utx_pkg::utx_word_t out_word_nxt;
  logic out_valid_r;
  logic out_valid_nxt;
  logic rd_pop;
  logic fwd_pulse_r;
  logic fwd_pulse_nxt;
  logic fwd_oe_r;
  logic fwd_oe_nxt;

  assign fill = wr_ptr_r - rd_ptr_r;
  assign room = utx_pkg::FIFO_DEPTH - fill;
  assign cell_words = wide_mode ? utx_pkg::CELL_WORDS_16 : utx_pkg::CELL_WORDS_8;
  assign port_idle = (fill == 8'h00) && (cell_pos_r == 7'h00) && !out_valid_r;

  // ==========================================================
  // cell bus write side
  always_comb
  begin
    addr_match = mphy_mode && (link_d_r.addr == port_r[4:0]);
    write_ok = atm_mode && !link_d_r.en_n && (!mphy_mode || sel_r);
    wr_data = wide_mode ? link_d_r.data : {8'h00, link_d_r.data[7:0]};
    par_bad = link_edge && write_ok && (link_d_r.par != ~^wr_data);
    pos_use = link_d_r.soc ? 7'h00 : cell_pos_r;
    wr_word = '{soc: link_d_r.soc, eoc: (pos_use == cell_words - 7'h01), data: wr_data};
    wr_push = link_edge && write_ok && (room != 8'h00);
    wr_ptr_nxt = wr_push ? wr_ptr_r + 8'h01 : wr_ptr_r;
    cell_pos_nxt = cell_pos_r;
    if (link_edge && write_ok)
      cell_pos_nxt = wr_word.eoc ? 7'h00 : pos_use + 7'h01;
    sel_nxt = sel_r;
    drv_nxt = drv_r;
    if (link_edge)
    begin
      drv_nxt = addr_match;
      if (link_d_r.en_n)
        sel_nxt = addr_match;
    end
    if (!mphy_mode)
    begin
      sel_nxt = 1'b0;
      drv_nxt = 1'b0;
    end
    if (cell_hs || mphy_mode)
      clav_nxt = room >= {1'b0, cell_words};
    else
      clav_nxt = room >= utx_pkg::OCTET_ROOM;
    clav_oe_nxt = atm_mode && (!mphy_mode || drv_r);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wr_ptr_r <= 8'h00;
      cell_pos_r <= 7'h00;
      sel_r <= 1'b0;
      drv_r <= 1'b0;
      clav_r <= 1'b0;
      clav_oe_r <= 1'b0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      cell_pos_r <= cell_pos_nxt;
      sel_r <= sel_nxt;
      drv_r <= drv_nxt;
      clav_r <= clav_nxt;
      clav_oe_r <= clav_oe_nxt;
    end
  end

  // storage holds no control state, so it needs no reset
  always_ff @(posedge clk)
  begin
    if (wr_push)
      mem[wr_ptr_r[utx_pkg::FIFO_AW-1:0]] <= wr_word;
  end

  // ==========================================================
  // downstream drain
  always_comb
  begin
    rd_pop = (fill != 8'h00) && (!out_valid_r || fwd_ready);
    rd_ptr_nxt = rd_pop ? rd_ptr_r + 8'h01 : rd_ptr_r;
    out_word_nxt = rd_pop ? mem[rd_ptr_r[utx_pkg::FIFO_AW-1:0]] : out_word_r;
    out_valid_nxt = rd_pop || (out_valid_r && !fwd_ready);
    fwd_pulse_nxt = atm_mode && out_valid_r && fwd_ready && out_word_r.eoc;
    fwd_oe_nxt = atm_mode;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rd_ptr_r <= 8'h00;
      out_word_r <= '0;
      out_valid_r <= 1'b0;
      fwd_pulse_r <= 1'b0;
      fwd_oe_r <= 1'b0;
    end
    else
    begin
      rd_ptr_r <= rd_ptr_nxt;
      out_word_r <= out_word_nxt;
      out_valid_r <= out_valid_nxt;
      fwd_pulse_r <= fwd_pulse_nxt;
      fwd_oe_r <= fwd_oe_nxt;
    end
  end

  // ==========================================================
  // register bus, zero wait state
  always_comb
  begin
    bus_take = hsel && htrans[1] && hready;
    ap_wr_nxt = bus_take && hwrite;
    ap_addr_nxt = bus_take ? haddr[7:0] : ap_addr_r;
    rd_status = bus_take && !hwrite && (haddr[7:0] == utx_pkg::ADDR_STATUS);
    hrdata_nxt = hrdata;
    if (bus_take && !hwrite)
    begin
      unique case (haddr[7:0])
        utx_pkg::ADDR_CTRL: hrdata_nxt = {28'h0000000, ctrl_r};
        utx_pkg::ADDR_STATUS: hrdata_nxt = {29'h00000000, status_r};
        utx_pkg::ADDR_MASK: hrdata_nxt = {29'h00000000, mask_r};
        utx_pkg::ADDR_FILL: hrdata_nxt = {24'h000000, fill};
        utx_pkg::ADDR_PORT: hrdata_nxt = {24'h000000, port_r};
        default: hrdata_nxt = 32'h00000000;
      endcase
    end
    ev_set = '0;
    ev_set[utx_pkg::ST_PARITY_BIT] = par_bad;
    ev_set[utx_pkg::ST_FWD_BIT] = fwd_pulse_nxt;
    ev_set[utx_pkg::ST_OVF_BIT] = link_edge && write_ok && (room == 8'h00);
    // a read clears, but an event in the same cycle survives it
    status_nxt = (rd_status ? 3'h0 : status_r) | ev_set;
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    port_nxt = port_r;
    if (ap_wr_r)
    begin
      unique case (ap_addr_r)
        utx_pkg::ADDR_CTRL:
        begin
          ctrl_nxt[utx_pkg::CTRL_ATM_BIT] = hwdata[utx_pkg::CTRL_ATM_BIT];
          if (port_idle)
            ctrl_nxt[3:1] = hwdata[3:1];
        end
        utx_pkg::ADDR_MASK: mask_nxt = hwdata[2:0];
        utx_pkg::ADDR_PORT: port_nxt = hwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl_r <= utx_pkg::CTRL_RST;
      status_r <= utx_pkg::STATUS_RST;
      mask_r <= utx_pkg::MASK_RST;
      port_r <= utx_pkg::PORT_ADDR_RST;
      ap_wr_r <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata <= 32'h00000000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      port_r <= port_nxt;
      ap_wr_r <= ap_wr_nxt;
      ap_addr_r <= ap_addr_nxt;
      hrdata <= hrdata_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(status_r & mask_r);
  assign cell_space_available = clav_r & clav_oe_r;
  assign cell_space_available_oe = clav_oe_r;
  assign cell_forwarded_pulse = fwd_pulse_r;
  assign cell_forwarded_oe = fwd_oe_r;
  assign fwd_valid = out_valid_r;
  assign fwd_start = out_word_r.soc;
  assign fwd_data = out_word_r.data;

  // ==========================================================
  // checks
  a_store_on_enable: assert property (@(posedge clk) disable iff (!nrst)
    (link_edge && write_ok && room != 8'h00) |=> (wr_ptr_r == $past(wr_ptr_r) + 8'h01))
    else $error("enabled write not stored");
  a_ignore_disabled: assert property (@(posedge clk) disable iff (!nrst)
    (link_edge && link_d_r.en_n) |=> (wr_ptr_r == $past(wr_ptr_r)))
    else $error("word stored while write enable high");
  a_parity_flag: assert property (@(posedge clk) disable iff (!nrst)
    (link_edge && write_ok && link_d_r.par == ^wr_data) |=> status_r[utx_pkg::ST_PARITY_BIT])
    else $error("parity mismatch not flagged");
  a_octet_room: assert property (@(posedge clk) disable iff (!nrst)
    (atm_mode && !cell_hs && !mphy_mode && $stable(ctrl_r))
    |=> (cell_space_available == ($past(room) >= utx_pkg::OCTET_ROOM)))
    else $error("octet space available wrong");
  a_cell_room: assert property (@(posedge clk) disable iff (!nrst)
    (atm_mode && cell_hs && !mphy_mode && $stable(ctrl_r))
    |=> (cell_space_available == ($past(room) >= {1'b0, $past(cell_words)})))
    else $error("cell space available wrong");
  a_mphy_float: assert property (@(posedge clk) disable iff (!nrst)
    (mphy_mode && $stable(ctrl_r) && link_edge && !addr_match) |=> ##1 !cell_space_available_oe)
    else $error("space available driven without address match");
  a_mphy_drive: assert property (@(posedge clk) disable iff (!nrst)
    (atm_mode && mphy_mode && $stable(ctrl_r) && link_edge && addr_match)
    |=> ##1 cell_space_available_oe)
    else $error("space available not driven after match");
  a_fwd_pulse: assert property (@(posedge clk) disable iff (!nrst)
    (atm_mode && fwd_valid && fwd_ready && out_word_r.eoc) |=> cell_forwarded_pulse ##1 1'b1)
    else $error("forwarded pulse missing");
  a_clear_mode_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !atm_mode [*2] |-> (!cell_space_available_oe && !cell_forwarded_pulse))
    else $error("outputs active in clear channel mode");
  a_reset_float: assert property (@(posedge clk)
    !nrst |=> (!cell_space_available_oe && !cell_forwarded_oe && ctrl_r == utx_pkg::CTRL_RST))
    else $error("outputs driven after reset");
  a_config_idle: assert property (@(posedge clk) disable iff (!nrst)
    !$past(port_idle) |-> (ctrl_r[3:1] == $past(ctrl_r[3:1])))
    else $error("configuration changed while busy");

  c_cell_forwarded: cover property (@(posedge clk) disable iff (!nrst) cell_forwarded_pulse);
  c_fifo_full: cover property (@(posedge clk) disable iff (!nrst) room == 8'h00);
  c_mphy_select: cover property (@(posedge clk) disable iff (!nrst)
    mphy_mode && cell_space_available_oe);
  c_parity_irq: cover property (@(posedge clk) disable iff (!nrst)
    irq && status_r[utx_pkg::ST_PARITY_BIT]);

endmodule : utx_tx_port

// File: shared/utx_pkg.sv
// Purpose: shared constants and types of the transmit cell port
// Assumes: AHB-Lite register bus with 32-bit data, one word per register
// Notes: fifo depth and cell lengths are fixed at build time
package utx_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_FILL = 8'h0C;
  localparam logic [7:0] ADDR_PORT = 8'h70;

  // ==========================================================
  // control fields
  localparam int CTRL_ATM_BIT = 0;
  localparam int CTRL_WIDE_BIT = 1;
  localparam int CTRL_CELL_HS_BIT = 2;
  localparam int CTRL_MPHY_BIT = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h1;

  // ==========================================================
  // status and mask fields
  localparam int ST_PARITY_BIT = 0;
  localparam int ST_FWD_BIT = 1;
  localparam int ST_OVF_BIT = 2;
  localparam int ST_W = 3;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [7:0] PORT_ADDR_RST = 8'h00;

  // ==========================================================
  // fifo and cell geometry
  localparam int FIFO_AW = 7;
  localparam logic [7:0] FIFO_DEPTH = 8'h80;
  localparam logic [7:0] OCTET_ROOM = 8'h04;
  localparam logic [6:0] CELL_WORDS_8 = 7'h35;
  localparam logic [6:0] CELL_WORDS_16 = 7'h1B;

  typedef struct packed {
    logic en_n;
    logic soc;
    logic par;
    logic [15:0] data;
    logic [4:0] addr;
  } utx_link_t;

  typedef struct packed {
    logic soc;
    logic eoc;
    logic [15:0] data;
  } utx_word_t;

endpackage : utx_pkg

// File: hdl/utx_sync.sv
// Purpose: two-flop synchroniser for a bundle of pins
// Assumes: each bit is sampled on its own, no bus coherency implied
// Notes: the first stage feeds only the second stage
`timescale 1ns/10ps
module utx_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ==========================================================
  // stages
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] dout_nxt;

  always_comb
  begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      dout <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      dout <= dout_nxt;
    end
  end

endmodule : utx_sync

// File: verif/utx_atm_master.sv
// Purpose: cell bus master model driving the transmit cell link
// Assumes: link clock made here, 200 ns period, running only inside transfers
// Notes: released data lines show the inverse of their last value; parity is inverted only by xfer, not at the end of send
`timescale 1ns/10ps
module utx_atm_master (
  output logic cell_bus_clock,
  output logic cell_write_enable_n,
  output logic cell_start_marker,
  output logic cell_word_parity,
  output logic [15:0] cell_data_bus,
  output logic [4:0] phy_port_address
);
  // ==========================================================
  // idle link
  initial
  begin
    cell_bus_clock = 1'b0;
    cell_write_enable_n = 1'b1;
    cell_start_marker = 1'b0;
    cell_word_parity = 1'b0;
    cell_data_bus = 16'h0000;
    phy_port_address = 5'h00;
  end

  // ==========================================================
  // one link clock period; lines change only while the link clock is low
  task xfer(input logic en, input logic soc, input logic [15:0] d, input logic wide,
    input logic bad, input logic [4:0] a);
    cell_write_enable_n <= ~en;
    cell_start_marker <= en & soc;
    phy_port_address <= a;
    cell_data_bus <= en ? d : ~cell_data_bus;
    cell_word_parity <= en ? ((wide ? ~^d : ~^d[7:0]) ^ bad) : ~cell_word_parity;
    #100 cell_bus_clock <= 1'b1;
    #100 cell_bus_clock <= 1'b0;
  endtask : xfer

  // n words from stream position p; a cell starts every len words
  task send(input int n, input int p, input int len, input logic wide, input int bad_at,
    input logic [4:0] a);
    int i;
    for (i = 0; i < n; i++)
    begin
      xfer(1'b1, ((p + i) % len) == 0, 16'hA500 + 16'(p + i), wide, i == bad_at, a);
    end
    cell_write_enable_n <= 1'b1;
    cell_data_bus <= ~cell_data_bus;
  endtask : send
endmodule : utx_atm_master

// File: verif/tb_top.sv
// Purpose: self-checking bench of the transmit cell port
// Assumes: zero-wait register bus; link words take effect a few clk after the link rise
// Notes: drain side stalls by holding fwd_ready low during threshold tests
`timescale 1ns/10ps
module tb_top;
  localparam int L8 = int'(utx_pkg::CELL_WORDS_8);
  localparam int L16 = int'(utx_pkg::CELL_WORDS_16);
  localparam int DEP = int'(utx_pkg::FIFO_DEPTH);
  localparam int ROOM = int'(utx_pkg::OCTET_ROOM);
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic fwd_ready = 1'b0;
  logic hready, hreadyout, hresp, irq, fwd_valid, fwd_start;
  logic [31:0] hrdata, rd_v;
  logic [15:0] fwd_data, cdata;
  logic clk_l, en_n, soc, par, clav, clav_oe, fwd_p, fwd_oe;
  logic [4:0] paddr;
  logic [16:0] seen[$];
  int n_fail = 0;
  int compares = 0;
  int n_pulse = 0;

  always #12.5 clk = ~clk;
  assign hready = hreadyout;

  utx_atm_master utx_atm_master_i (.cell_bus_clock(clk_l), .cell_write_enable_n(en_n),
    .cell_start_marker(soc), .cell_word_parity(par), .cell_data_bus(cdata),
    .phy_port_address(paddr));

  utx_tx_port utx_tx_port_i (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .cell_bus_clock(clk_l), .cell_write_enable_n(en_n), .cell_start_marker(soc),
    .cell_word_parity(par), .cell_data_bus(cdata), .phy_port_address(paddr),
    .cell_space_available(clav), .cell_space_available_oe(clav_oe),
    .cell_forwarded_pulse(fwd_p), .cell_forwarded_oe(fwd_oe), .fwd_ready(fwd_ready),
    .fwd_valid(fwd_valid), .fwd_start(fwd_start), .fwd_data(fwd_data));

  // ==========================================================
  // drain monitor
  always @(posedge clk)
  begin
    if (fwd_valid === 1'b1 && fwd_ready === 1'b1) seen.push_back({fwd_start, fwd_data});
    if (fwd_p === 1'b1) n_pulse++;
  end

  // ==========================================================
  // compare and bus tasks
  task check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    compares++;
    if (seen_v !== exp_v)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask : check

  task chk1(input logic v, input logic e);
    check(32'(v), 32'(e));
  endtask : chk1

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd_v = hrdata;
  endtask : ahb

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(rd_v, e);
  endtask : rd_chk

  task settle;
    repeat (12) @(posedge clk);
  endtask : settle

  task end_of_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // a hang counts as a mismatch; the run needs well under a tenth of this
  initial
  begin
    #1000000;
    n_fail++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(utx_pkg::ADDR_CTRL, 32'(utx_pkg::CTRL_RST));
    rd_chk(utx_pkg::ADDR_STATUS, 32'h0);
    rd_chk(utx_pkg::ADDR_MASK, 32'h0);
    rd_chk(utx_pkg::ADDR_FILL, 32'h0);
    rd_chk(utx_pkg::ADDR_PORT, 32'h0);
    rd_chk(8'h40, 32'h0);
    chk1(clav_oe, 1'b1);
    chk1(clav, 1'b1);
    chk1(hresp, 1'b0);
    $display("test reset done");
    ahb(1'b1, utx_pkg::ADDR_CTRL, 32'h0);
    settle();
    chk1(clav_oe, 1'b0);
    chk1(fwd_oe, 1'b0);
    utx_atm_master_i.send(2, 0, L8, 1'b0, -1, 5'h00);
    settle();
    rd_chk(utx_pkg::ADDR_FILL, 32'h0);
    ahb(1'b1, utx_pkg::ADDR_CTRL, 32'h1);
    repeat (3) utx_atm_master_i.xfer(1'b0, 1'b0, 16'h1234, 1'b0, 1'b0, 5'h00);
    settle();
    rd_chk(utx_pkg::ADDR_FILL, 32'h0);
    utx_atm_master_i.send(3, 0, L8, 1'b0, -1, 5'h00);
    settle();
    // the first word moves on into the downstream holding stage
    rd_chk(utx_pkg::ADDR_FILL, 32'h2);
    chk1(fwd_valid, 1'b1);
    rd_chk(utx_pkg::ADDR_STATUS, 32'h0);
    $display("test capture done");
    ahb(1'b1, utx_pkg::ADDR_MASK, 32'h1);
    settle();
    chk1(irq, 1'b0);
    utx_atm_master_i.send(1, 3, L8, 1'b0, 0, 5'h00);
    settle();
    chk1(irq, 1'b1);
    rd_chk(utx_pkg::ADDR_STATUS, 32'h1);
    settle();
    chk1(irq, 1'b0);
    rd_chk(utx_pkg::ADDR_STATUS, 32'h0);
    fwd_ready <= 1'b1;
    settle();
    check(32'(seen.size()), 32'h4);
    check(32'(seen[0]), 32'h00010000);
    check(32'(seen[3]), 32'h00000003);
    fwd_ready <= 1'b0;
    $display("test parity done");
    utx_atm_master_i.send(DEP - ROOM + 1, 4, L8, 1'b0, -1, 5'h00);
    settle();
    chk1(clav, 1'b1);
    utx_atm_master_i.send(1, DEP - ROOM + 5, L8, 1'b0, -1, 5'h00);
    settle();
    chk1(clav, 1'b0);
    ahb(1'b1, utx_pkg::ADDR_CTRL, 32'h5);
    rd_chk(utx_pkg::ADDR_CTRL, 32'h1);
    fwd_ready <= 1'b1;
    utx_atm_master_i.send(3 * L8 - DEP - 2, DEP + 2, L8, 1'b0, -1, 5'h00);
    settle();
    rd_chk(utx_pkg::ADDR_FILL, 32'h0);
    check(32'(n_pulse), 32'h3);
    chk1(irq, 1'b0);
    rd_chk(utx_pkg::ADDR_STATUS, 32'h2);
    fwd_ready <= 1'b0;
    $display("test octet done");
    ahb(1'b1, utx_pkg::ADDR_CTRL, 32'h5);
    rd_chk(utx_pkg::ADDR_CTRL, 32'h5);
    utx_atm_master_i.send(DEP - L8 + 1, 0, L8, 1'b0, -1, 5'h00);
    settle();
    chk1(clav, 1'b1);
    utx_atm_master_i.send(1, DEP - L8 + 1, L8, 1'b0, -1, 5'h00);
    settle();
    chk1(clav, 1'b0);
    fwd_ready <= 1'b1;
    utx_atm_master_i.send(3 * L8 - DEP - 2, DEP - L8 + 2, L8, 1'b0, -1, 5'h00);
    settle();
    check(32'(n_pulse), 32'h5);
    $display("test cell level done");
    ahb(1'b1, utx_pkg::ADDR_CTRL, 32'h7);
    seen.delete();
    utx_atm_master_i.send(L16, 0, L16, 1'b1, -1, 5'h00);
    settle();
    check(32'(seen[1]), 32'h0000A501);
    check(32'(n_pulse), 32'h6);
    rd_chk(utx_pkg::ADDR_STATUS, 32'h2);
    fwd_ready <= 1'b0;
    $display("test wide done");
    ahb(1'b1, utx_pkg::ADDR_PORT, 32'h5);
    ahb(1'b1, utx_pkg::ADDR_CTRL, 32'hD);
    rd_chk(utx_pkg::ADDR_CTRL, 32'hD);
    utx_atm_master_i.xfer(1'b0, 1'b0, 16'h0000, 1'b0, 1'b0, 5'h03);
    settle();
    chk1(clav_oe, 1'b0);
    utx_atm_master_i.xfer(1'b0, 1'b0, 16'h0000, 1'b0, 1'b0, 5'h05);
    settle();
    chk1(clav_oe, 1'b1);
    chk1(clav, 1'b1);
    utx_atm_master_i.xfer(1'b0, 1'b0, 16'h0000, 1'b0, 1'b0, 5'h03);
    settle();
    chk1(clav_oe, 1'b0);
    $display("test multi port done");
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    chk1(fwd_oe, 1'b0);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(utx_pkg::ADDR_PORT, 32'h0);
    $display("test second reset done");
    end_of_test();
  end
endmodule : tb_top
